/* design/lsm_pkg.sv */
// Shared constants and types of the point-to-point link state machine
package lsm_pkg;

   // ------------------------------------------------------------
   // Link states, coded as state number minus one
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_TEI_UNASSIGNED = 3'h0,
      ST_ASSIGN_AWAIT = 3'h1,
      ST_EST_AWAIT = 3'h2,
      ST_TEI_ASSIGNED = 3'h3,
      ST_AWAIT_EST = 3'h4,
      ST_AWAIT_REL = 3'h5,
      ST_MFE = 3'h6,
      ST_TIMER_REC = 3'h7
   } lsm_state_type;

   // ------------------------------------------------------------
   // Held-back event bits, lower index is served first
   // ------------------------------------------------------------
   localparam int NEV = 12;
   localparam int EV_TEI_REMOVE = 0;
   localparam int EV_TEI_DIRECT = 1;
   localparam int EV_TEI_ASSIGN = 2;
   localparam int EV_PEER_REL = 3;
   localparam int EV_REL = 4;
   localparam int EV_PEER_EST = 5;
   localparam int EV_PEER_UA = 6;
   localparam int EV_FINAL = 7;
   localparam int EV_T200 = 8;
   localparam int EV_T203 = 9;
   localparam int EV_EST = 10;
   localparam int EV_UD = 11;

   // ------------------------------------------------------------
   // Procedure limits and error codes (0 = A ... 14 = O)
   // ------------------------------------------------------------
   localparam logic [1:0] N200 = 2'h3;
   localparam logic [2:0] K_WINDOW = 3'h1;
   localparam logic [3:0] ERR_UNSOLICITED_UA = 4'h2;
   localparam logic [3:0] ERR_RETRY_LIMIT = 4'h8;
   localparam logic [3:0] ERR_CODE_MAX = 4'he;
   localparam int QCOUNT_W = 16;
   localparam logic [QCOUNT_W-1:0] QCOUNT_MAX = 16'hffff;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint CLK_HZ = 125000000;
   localparam longint T200_MS = 1000;
   localparam longint T203_S = 10;
   localparam longint T200_CYCLES = T200_MS * CLK_HZ / 1000;
   localparam longint T203_CYCLES = T203_S * CLK_HZ;

endpackage : lsm_pkg

/* design/lsm_tmr_if.sv */
// Start, stop and expiry signals between the state machine and one timer
`timescale 1ns/10ps
`default_nettype none
interface lsm_tmr_if;
   logic start;
   logic stop;
   logic expired;
   modport ctl (output start, output stop, input expired);
   modport tmr (input start, input stop, output expired);
endinterface : lsm_tmr_if
`default_nettype wire

/* design/lsm_tick_timer.sv */
// Restartable one-shot cycle timer with a one-cycle expiry pulse
`timescale 1ns/10ps
`default_nettype none
module lsm_tick_timer
   import lsm_pkg::*;
#(
   parameter logic [31:0] LOAD = 32'h00000010
) (
   input wire logic mclk,
   input wire logic rst,
   lsm_tmr_if.tmr tif
);
   typedef struct packed {
      logic [31:0] cnt;
      logic run;
      logic expired;
   } lsm_tmr_type;

   lsm_tmr_type q, d;

   always_comb begin
      d = q;
      d.expired = 1'b0;
      // Start wins over stop so a restart is never lost
      if (tif.start) begin
         d.cnt = LOAD;
         d.run = 1'b1;
      end else if (tif.stop) begin
         d.run = 1'b0;
      end else if (q.run) begin
         if (q.cnt <= 32'h00000001) begin
            d.run = 1'b0;
            d.expired = 1'b1;
         end else begin
            d.cnt = q.cnt - 32'h00000001;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tif.expired = q.expired;
endmodule : lsm_tick_timer
`default_nettype wire

/* design/lsm_frame_queue.sv */
// Frame queue bookkeeping: pending count and a queued-up event pulse
`timescale 1ns/10ps
`default_nettype none
module lsm_frame_queue
   import lsm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic push,
   input wire logic pop,
   output logic queued,
   output logic not_empty
);
   typedef struct packed {
      logic [QCOUNT_W-1:0] cnt;
      logic queued;
   } lsm_que_type;

   lsm_que_type q, d;

   always_comb begin
      d = q;
      d.queued = push;
      // Count saturates; at this width software never reaches it in practice
      if (push && !(pop && q.cnt != '0)) begin
         if (q.cnt != QCOUNT_MAX) begin
            d.cnt = q.cnt + 16'h0001;
         end
      end else if (pop && !push && q.cnt != '0) begin
         d.cnt = q.cnt - 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign queued = q.queued;
   assign not_empty = (q.cnt != '0);
endmodule : lsm_frame_queue
`default_nettype wire

/* design/lsm_link_fsm.sv */
// Top state machine of a point-to-point D-channel data link entity
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// ------------------------------------------------------------
module lsm_link_fsm
   import lsm_pkg::*;
#(
   parameter logic [31:0] T200_LOAD = 32'(T200_CYCLES),
   parameter logic [31:0] T203_LOAD = 32'(T203_CYCLES)
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ud_req,
   input wire logic est_req,
   input wire logic rel_req,
   input wire logic data_req,
   input wire logic tei_assigned,
   input wire logic tei_direct,
   input wire logic tei_removed,
   input wire logic peer_establish,
   input wire logic peer_release,
   input wire logic peer_ua,
   input wire logic peer_final,
   input wire logic peer_ack,
   input wire logic frame_seen,
   input wire logic peer_busy_set,
   input wire logic peer_busy_clr,
   input wire logic reject_set,
   input wire logic reject_clr,
   input wire logic own_busy_set,
   input wire logic own_busy_clr,
   output logic [2:0] link_state,
   output logic tei_request,
   output logic send_sabme,
   output logic send_disc,
   output logic send_poll,
   output logic poll_rnr,
   output logic send_ui,
   output logic send_i,
   output logic error_ind,
   output logic [3:0] error_code,
   output logic peer_busy,
   output logic reject_exception,
   output logic own_busy,
   output logic [1:0] retransmission_counter
);
   // ------------------------------------------------------------
   // State record
   // ------------------------------------------------------------
   typedef struct packed {
      lsm_state_type state;
      logic [NEV-1:0] pend;
      logic settle;
      logic [1:0] rc;
      logic peer_busy;
      logic reject_exc;
      logic own_busy;
      logic tei_req;
      logic send_sabme;
      logic send_disc;
      logic send_poll;
      logic poll_rnr;
      logic send_ui;
      logic send_i;
      logic err_ind;
      logic [3:0] err_code;
      logic ui_svc;
      logic i_svc;
      logic [2:0] outstanding;
      logic t200_start;
      logic t200_stop;
      logic t203_start;
      logic t203_stop;
   } lsm_fsm_type;

   lsm_fsm_type q, d;
   lsm_state_type nxt;
   logic [NEV-1:0] arr;
   logic [NEV-1:0] ev;
   logic ui_queued, ui_ne, i_queued, i_ne;
   logic ui_fire, i_fire;

   function automatic logic [NEV-1:0] first_one(input logic [NEV-1:0] v);
      return v & (~v + {{(NEV-1){1'b0}}, 1'b1});
   endfunction : first_one

   function automatic logic in_mfe(input lsm_state_type s);
      return (s == ST_MFE) || (s == ST_TIMER_REC);
   endfunction : in_mfe

   function automatic logic retry_ok(input logic [1:0] rc);
      return rc < N200;
   endfunction : retry_ok

   // ------------------------------------------------------------
   // Timers and queues
   // ------------------------------------------------------------
   lsm_tmr_if t200_if ();
   lsm_tmr_if t203_if ();

   lsm_tick_timer #(.LOAD(T200_LOAD)) u_t200 (
      .mclk(mclk),
      .rst(rst),
      .tif(t200_if.tmr)
   );

   // Idle supervision, ten seconds unless overridden
   lsm_tick_timer #(.LOAD(T203_LOAD)) u_t203 (
      .mclk(mclk),
      .rst(rst),
      .tif(t203_if.tmr)
   );

   assign t200_if.start = q.t200_start;
   assign t200_if.stop = q.t200_stop;
   assign t203_if.start = q.t203_start;
   assign t203_if.stop = q.t203_stop;

   // Two independent queues, only counts are kept here
   lsm_frame_queue u_ui_q (
      .mclk(mclk),
      .rst(rst),
      .push(ud_req),
      .pop(ui_fire),
      .queued(ui_queued),
      .not_empty(ui_ne)
   );

   lsm_frame_queue u_i_q (
      .mclk(mclk),
      .rst(rst),
      .push(data_req),
      .pop(i_fire),
      .queued(i_queued),
      .not_empty(i_ne)
   );

   // Queue service leaves the link state alone
   assign ui_fire = q.ui_svc && ui_ne && (q.state >= ST_TEI_ASSIGNED);
   // Window and peer busy gate the I queue
   assign i_fire = q.i_svc && i_ne && (q.state == ST_MFE) && !q.peer_busy && (q.outstanding < K_WINDOW);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      d.send_sabme = 1'b0;
      d.send_disc = 1'b0;
      d.send_poll = 1'b0;
      d.send_ui = ui_fire;
      d.send_i = i_fire;
      d.err_ind = 1'b0;
      d.settle = 1'b0;
      d.t200_start = 1'b0;
      d.t200_stop = 1'b0;
      d.t203_start = 1'b0;
      d.t203_stop = 1'b0;
      arr = '0;
      arr[EV_TEI_REMOVE] = tei_removed;
      arr[EV_TEI_DIRECT] = tei_direct;
      arr[EV_TEI_ASSIGN] = tei_assigned;
      arr[EV_PEER_REL] = peer_release;
      arr[EV_REL] = rel_req;
      arr[EV_PEER_EST] = peer_establish;
      arr[EV_PEER_UA] = peer_ua;
      arr[EV_FINAL] = peer_final;
      arr[EV_T200] = t200_if.expired;
      arr[EV_T203] = t203_if.expired;
      arr[EV_EST] = est_req;
      arr[EV_UD] = ud_req;
      // Nothing is served in the settling cycle; arrivals are merged, never lost
      ev = q.settle ? '0 : first_one(q.pend);
      d.pend = (q.pend & ~ev) | arr;
      nxt = q.state;

      // Queued-up pulses open a service window until the queue drains
      d.ui_svc = ui_queued || (q.ui_svc && ui_ne);
      d.i_svc = i_queued || (q.i_svc && i_ne);
      if (i_fire && !peer_ack) begin
         d.outstanding = q.outstanding + 3'h1;
      end else if (peer_ack && !i_fire && q.outstanding != 3'h0) begin
         d.outstanding = q.outstanding - 3'h1;
      end

      if (ev[EV_TEI_REMOVE]) begin
         nxt = ST_TEI_UNASSIGNED;
      end else begin
         unique case (q.state)
            ST_TEI_UNASSIGNED: begin
               if (ev[EV_TEI_DIRECT]) begin
                  nxt = ST_TEI_ASSIGNED;
               end else if (ev[EV_UD]) begin
                  nxt = ST_ASSIGN_AWAIT;
               end else if (ev[EV_EST]) begin
                  nxt = ST_EST_AWAIT;
               end
            end
            ST_ASSIGN_AWAIT: begin
               if (ev[EV_TEI_ASSIGN] || ev[EV_TEI_DIRECT]) begin
                  nxt = ST_TEI_ASSIGNED;
               end else if (ev[EV_EST]) begin
                  nxt = ST_EST_AWAIT;
               end
            end
            ST_EST_AWAIT: begin
               if (ev[EV_TEI_ASSIGN] || ev[EV_TEI_DIRECT]) begin
                  nxt = ST_AWAIT_EST;
                  d.send_sabme = 1'b1;
                  d.rc = 2'h0;
                  d.t200_start = 1'b1;
               end
            end
            ST_TEI_ASSIGNED: begin
               if (ev[EV_PEER_EST]) begin
                  nxt = ST_MFE;
               end else if (ev[EV_EST]) begin
                  nxt = ST_AWAIT_EST;
                  d.send_sabme = 1'b1;
                  d.rc = 2'h0;
                  d.t200_start = 1'b1;
               end else if (ev[EV_PEER_UA]) begin
                  d.err_ind = 1'b1;
                  d.err_code = ERR_UNSOLICITED_UA;
               end
            end
            ST_AWAIT_EST: begin
               if (ev[EV_PEER_REL]) begin
                  nxt = ST_TEI_ASSIGNED;
               end else if (ev[EV_PEER_UA] || ev[EV_PEER_EST]) begin
                  nxt = ST_MFE;
               end else if (ev[EV_T200]) begin
                  if (retry_ok(q.rc)) begin
                     d.rc = q.rc + 2'h1;
                     d.send_sabme = 1'b1;
                     d.t200_start = 1'b1;
                  end else begin
                     nxt = ST_TEI_ASSIGNED;
                     d.err_ind = 1'b1;
                     d.err_code = ERR_RETRY_LIMIT;
                  end
               end
            end
            ST_AWAIT_REL: begin
               if (ev[EV_PEER_UA] || ev[EV_PEER_REL]) begin
                  nxt = ST_TEI_ASSIGNED;
               end else if (ev[EV_T200]) begin
                  if (retry_ok(q.rc)) begin
                     d.rc = q.rc + 2'h1;
                     d.send_disc = 1'b1;
                     d.t200_start = 1'b1;
                  end else begin
                     nxt = ST_TEI_ASSIGNED;
                     d.err_ind = 1'b1;
                     d.err_code = ERR_RETRY_LIMIT;
                  end
               end
            end
            ST_MFE: begin
               if (ev[EV_PEER_REL]) begin
                  nxt = ST_TEI_ASSIGNED;
               end else if (ev[EV_REL]) begin
                  nxt = ST_AWAIT_REL;
                  d.send_disc = 1'b1;
                  d.rc = 2'h0;
                  d.t200_start = 1'b1;
               end else if (ev[EV_T200] || ev[EV_T203]) begin
                  nxt = ST_TIMER_REC;
                  d.rc = 2'h0;
                  d.send_poll = 1'b1;
                  d.poll_rnr = q.own_busy;
                  d.t200_start = 1'b1;
               end else if (ev[EV_PEER_UA]) begin
                  d.err_ind = 1'b1;
                  d.err_code = ERR_UNSOLICITED_UA;
               end
            end
            ST_TIMER_REC: begin
               if (ev[EV_PEER_REL]) begin
                  nxt = ST_TEI_ASSIGNED;
               end else if (ev[EV_REL]) begin
                  nxt = ST_AWAIT_REL;
                  d.send_disc = 1'b1;
                  d.rc = 2'h0;
                  d.t200_start = 1'b1;
               end else if (ev[EV_FINAL]) begin
                  nxt = ST_MFE;
               end else if (ev[EV_T200]) begin
                  if (retry_ok(q.rc)) begin
                     d.rc = q.rc + 2'h1;
                     d.send_poll = 1'b1;
                     d.poll_rnr = q.own_busy;
                     d.t200_start = 1'b1;
                  end else begin
                     // Give up on the peer and start establishment afresh
                     nxt = ST_AWAIT_EST;
                     d.err_ind = 1'b1;
                     d.err_code = ERR_RETRY_LIMIT;
                     d.send_sabme = 1'b1;
                     d.rc = 2'h0;
                     d.t200_start = 1'b1;
                  end
               end
            end
         endcase
      end

      // Entry and exit actions shared by all transitions
      if (nxt != q.state) begin
         d.settle = 1'b1;
         if (nxt == ST_MFE) begin
            d.t200_stop = 1'b1;
            d.t203_start = 1'b1;
            d.outstanding = 3'h0;
         end
         if (q.state == ST_MFE) begin
            d.t203_stop = 1'b1;
         end
         if (nxt <= ST_TEI_ASSIGNED) begin
            d.t200_stop = 1'b1;
         end
      end else if (q.state == ST_MFE && frame_seen && !d.t200_start) begin
         d.t203_start = 1'b1;
      end

      // Conditions live only in 7 and 8; set wins over clear
      if (in_mfe(q.state) && in_mfe(nxt)) begin
         d.peer_busy = peer_busy_set || (q.peer_busy && !peer_busy_clr);
         d.reject_exc = reject_set || (q.reject_exc && !reject_clr);
         d.own_busy = own_busy_set || (q.own_busy && !own_busy_clr);
      end else begin
         d.peer_busy = 1'b0;
         d.reject_exc = 1'b0;
         d.own_busy = 1'b0;
      end

      d.state = nxt;
      d.tei_req = (nxt <= ST_EST_AWAIT);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= '0;
         q.tei_req <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link_state = q.state;
   assign tei_request = q.tei_req;
   assign send_sabme = q.send_sabme;
   assign send_disc = q.send_disc;
   assign send_poll = q.send_poll;
   assign poll_rnr = q.poll_rnr;
   assign send_ui = q.send_ui;
   assign send_i = q.send_i;
   assign error_ind = q.err_ind;
   assign error_code = q.err_code;
   assign peer_busy = q.peer_busy;
   assign reject_exception = q.reject_exc;
   assign own_busy = q.own_busy;
   assign retransmission_counter = q.rc;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence seq_idle_expiry;
      q.state == ST_MFE && ev[EV_T203];
   endsequence

   sequence seq_recovery_final;
      q.state == ST_TIMER_REC && ev[EV_FINAL];
   endsequence

   reset_state_a: assert property ($past(rst) |-> q.state == ST_TEI_UNASSIGNED && q.tei_req)
      else $error("not in state 1 with TEI request after reset");
   tei_remove_a: assert property (ev[EV_TEI_REMOVE] |=> q.state == ST_TEI_UNASSIGNED ##1 q.settle == 1'b0)
      else $error("TEI removal did not return to state 1");
   direct_assign_a: assert property (q.state == ST_TEI_UNASSIGNED && ev[EV_TEI_DIRECT]
      |=> q.state == ST_TEI_ASSIGNED)
      else $error("direct assignment did not reach state 4");
   peer_release_a: assert property (in_mfe(q.state) && ev[EV_PEER_REL] |=> q.state == ST_TEI_ASSIGNED)
      else $error("peer release did not go straight to state 4");
   idle_expiry_a: assert property (seq_idle_expiry |=> q.state == ST_TIMER_REC && q.rc == 2'h0 && q.send_poll
      && q.t200_start && q.poll_rnr == $past(q.own_busy) ##1 !q.send_poll)
      else $error("idle expiry handling wrong");
   recovery_exit_a: assert property (seq_recovery_final |=> q.state == ST_MFE && q.t203_start && q.t200_stop)
      else $error("final response did not restore state 7");
   settle_hold_a: assert property ($changed(q.state) |-> q.settle && ev == '0)
      else $error("event served during transition");
   ui_keep_state_a: assert property (ui_fire && ev == '0 |=> q.send_ui && q.state == $past(q.state))
      else $error("UI service changed the state");
   i_only_mfe_a: assert property (q.send_i |-> $past(q.state) == ST_MFE && !$past(q.peer_busy))
      else $error("I frame sent outside state 7");
   cond_scope_a: assert property (!in_mfe(q.state) |-> !q.peer_busy && !q.reject_exc && !q.own_busy)
      else $error("condition flag set outside states 7 and 8");
   one_code_a: assert property (q.err_ind |-> q.err_code <= ERR_CODE_MAX ##1 !q.err_ind)
      else $error("error code out of range");
   est_done_a: assert property (q.state == ST_AWAIT_EST && ev[EV_PEER_UA] |=> q.state == ST_MFE ##1 q.settle == 1'b0)
      else $error("completed establishment did not reach state 7");
endmodule : lsm_link_fsm
`default_nettype wire

/* testbench/lsm_peer_model.sv */
// Peer entity model: answers SABME and DISC with UA after a random delay
`timescale 1ns/10ps
`default_nettype none
module lsm_peer_model (
   input wire logic mclk,
   input wire logic send_sabme,
   input wire logic send_disc,
   output logic peer_ua
);
   int unsigned gap;
   initial peer_ua = 1'b0;
   // Prompt or slow, but always inside the retry timer so no retry is forced
   always @(posedge mclk) begin
      if (send_sabme === 1'b1 || send_disc === 1'b1) begin
         gap = $urandom_range(8, 0);
         repeat (gap) @(posedge mclk);
         #1 peer_ua = 1'b1;
         @(posedge mclk);
         #1 peer_ua = 1'b0;
      end
   end
endmodule : lsm_peer_model
`default_nettype wire

/* testbench/lsm_link_fsm_tb.sv */
// Self-checking bench of the link state machine
`timescale 1ns/10ps
`default_nettype none
module lsm_link_fsm_tb;
   import lsm_pkg::*;
   localparam int UD = 0, EST = 1, REL = 2, DAT = 3, ASG = 4, DIR = 5, REM = 6, PEST = 7;
   localparam int PREL = 8, UA = 9, FIN = 10, ACK = 11, SEEN = 12, OBS = 13;
   logic mclk, rst, p_ua, tei_request, send_sabme, send_disc, send_poll, poll_rnr;
   logic send_ui, send_i, error_ind, peer_busy, reject_exception, own_busy;
   logic [18:0] stim;
   logic [2:0] link_state, prev_ls, conds;
   logic [3:0] error_code;
   logic [1:0] retransmission_counter;
   logic [3:0] exp_ls[$];
   logic [3:0] exp_err[$];
   int err_total, cmp_count, ui_cnt, i_cnt;
   assign conds = {reject_exception, peer_busy, own_busy};

   lsm_link_fsm #(.T200_LOAD(32'h00000014), .T203_LOAD(32'h00000032)) lsm_link_fsm_i (
      .mclk(mclk), .rst(rst), .ud_req(stim[0]), .est_req(stim[1]), .rel_req(stim[2]),
      .data_req(stim[3]), .tei_assigned(stim[4]), .tei_direct(stim[5]), .tei_removed(stim[6]),
      .peer_establish(stim[7]), .peer_release(stim[8]), .peer_ua(stim[9] | p_ua),
      .peer_final(stim[10]), .peer_ack(stim[11]), .frame_seen(stim[12]),
      .own_busy_set(stim[13]), .own_busy_clr(stim[14]), .peer_busy_set(stim[15]),
      .peer_busy_clr(stim[16]), .reject_set(stim[17]), .reject_clr(stim[18]),
      .link_state(link_state), .tei_request(tei_request), .send_sabme(send_sabme),
      .send_disc(send_disc), .send_poll(send_poll), .poll_rnr(poll_rnr), .send_ui(send_ui),
      .send_i(send_i), .error_ind(error_ind), .error_code(error_code), .peer_busy(peer_busy),
      .reject_exception(reject_exception), .own_busy(own_busy),
      .retransmission_counter(retransmission_counter));

   lsm_peer_model lsm_peer_model_i (.mclk(mclk), .send_sabme(send_sabme), .send_disc(send_disc),
      .peer_ua(p_ua));

   always #4 mclk = ~mclk;

   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop;
      if (err_total == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   task automatic pulse(input int idx);
      repeat ($urandom_range(2, 0)) @(posedge mclk);
      @(posedge mclk);
      #1 stim[idx] = 1'b1;
      @(posedge mclk);
      #1 stim[idx] = 1'b0;
   endtask : pulse

   // Bounded wait; a state that never comes is a mismatch
   task automatic wait_ls(input logic [2:0] v);
      int n;
      n = 0;
      while (link_state !== v && n < 400) begin
         @(posedge mclk);
         #2;
         n++;
      end
      if (n == 400) chk({1'b0, link_state}, {1'b0, v});
   endtask : wait_ls

   // Output watcher: every state change and every error pulse retires the oldest note
   always @(posedge mclk) begin
      if (rst === 1'b0) begin
         if (link_state !== prev_ls) begin
            chk({1'b0, link_state}, exp_ls.size() > 0 ? exp_ls.pop_front() : 4'hf);
            if (link_state === 3'h7) chk({2'h0, retransmission_counter}, 4'h0);
         end
         if (error_ind === 1'b1) chk(error_code, exp_err.size() > 0 ? exp_err.pop_front() : 4'hf);
         if (send_poll === 1'b1) chk({3'h0, poll_rnr}, 4'h1);
         chk({3'h0, tei_request}, {3'h0, link_state <= 3'h2});
         if (send_sabme === 1'b1) chk({1'b0, link_state}, 4'h4);
         if (send_disc === 1'b1) chk({1'b0, link_state}, 4'h5);
         if (send_ui === 1'b1) begin
            ui_cnt++;
            chk({3'h0, link_state >= 3'h3}, 4'h1);
         end
         if (send_i === 1'b1) begin
            i_cnt++;
            chk({1'b0, link_state}, 4'h6);
         end
      end
      prev_ls <= link_state;
   end

   initial begin
      #(8 * 6000);
      err_total++;
      report_and_stop;
   end

   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      stim = '0;
      err_total = 0;
      cmp_count = 0;
      ui_cnt = 0;
      i_cnt = 0;
      void'($urandom(78));
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      chk({1'b0, link_state}, 4'h0);
      chk({3'h0, tei_request}, 4'h1);
      exp_ls = '{4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'h6, 4'h5, 4'h3};
      pulse(UD);
      pulse(ASG);
      wait_ls(3'h3);
      exp_err.push_back(ERR_UNSOLICITED_UA);
      pulse(UA);
      pulse(EST);
      wait_ls(3'h6);
      pulse(SEEN);
      pulse(DAT);
      pulse(ACK);
      for (int k = 0; k < 3; k++) begin
         pulse(OBS + 2 * k);
         @(posedge mclk);
         #2;
         chk({3'h0, conds[k]}, 4'h1);
         pulse(OBS + 1 + 2 * k);
         @(posedge mclk);
         #2;
         chk({3'h0, conds[k]}, 4'h0);
      end
      pulse(OBS);
      wait_ls(3'h7);
      pulse(FIN);
      wait_ls(3'h6);
      pulse(REL);
      wait_ls(3'h3);
      repeat (2) @(posedge mclk);
      chk(4'(exp_ls.size()), 4'h0);
      exp_ls = '{4'h6, 4'h3, 4'h0, 4'h2, 4'h4, 4'h6, 4'h0, 4'h3};
      pulse(PEST);
      wait_ls(3'h6);
      pulse(UD);
      pulse(PREL);
      wait_ls(3'h3);
      pulse(REM);
      wait_ls(3'h0);
      pulse(EST);
      pulse(ASG);
      wait_ls(3'h6);
      pulse(REM);
      wait_ls(3'h0);
      pulse(DIR);
      wait_ls(3'h3);
      repeat (4) @(posedge mclk);
      chk(4'(exp_ls.size() + exp_err.size()), 4'h0);
      chk(4'(ui_cnt), 4'h2);
      chk(4'(i_cnt), 4'h1);
      report_and_stop;
   end
endmodule : lsm_link_fsm_tb
`default_nettype wire
